// ===== dv/hbis_mem_model.sv
`timescale 1ns/10ps
// ==========
// core memory behind the arbiter, grant after dly waits
module hbis_mem_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [1:0] mem_wbe,
    input wire logic [3:0] dly,
    output logic mem_grant,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem_q [0:15];
    logic [3:0] cnt_q;
    logic [15:0] rd_q;
    // data is only valid with grant, scrambled otherwise
    assign mem_rdata = mem_grant ? rd_q : ~rd_q;
    // memory starts cleared
    initial begin
        for (int i = 0; i < 16; i++) mem_q[i] = 16'h0000;
    end
    // one-cycle grant pulse; a request still held is granted again after dly+1 more waits
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mem_grant <= 1'h0;
            cnt_q <= 4'h0;
        end else begin
            mem_grant <= 1'h0;
            if (mem_req && !mem_grant) begin
                if (cnt_q >= dly) begin
                    mem_grant <= 1'h1;
                    cnt_q <= 4'h0;
                    rd_q <= mem_q[mem_addr[4:1]];
                    if (mem_write && mem_wbe[0]) mem_q[mem_addr[4:1]][7:0] <= mem_wdata[7:0];
                    if (mem_write && mem_wbe[1]) mem_q[mem_addr[4:1]][15:8] <= mem_wdata[15:8];
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule // hbis_mem_model

// ===== dv/hbis_tb.sv
`timescale 1ns/10ps
// ==========
// bench for the host port straps and generic cycles
module hbis_tb;
    import hbis_pkg::*;
    logic mclk, rst_b, host_bus_clock, bus_status_strap, chip_select_b, mem_write, mem_req;
    logic low_byte_write_strobe, high_byte_write_strobe, low_byte_read_strobe;
    logic high_byte_read_strobe, mem_grant, stall_b, big_endian, panel_power_out, panel_power_on;
    logic [2:0] host_bus_select_straps;
    logic [1:0] misc_config_straps, mem_wbe;
    logic [15:0] host_addr_in, host_data_i, host_data_o, host_data_oe_b;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [3:0] personality, dly;
    int num_errors, n_tests, cyc;
    logic host_cycle_done_b;
    // glue: stall inverted into the host's done, driven only under chip select
    assign host_cycle_done_b = chip_select_b | ~stall_b;
    hbis_pers_e xp_tab [0:6] = '{HBIS_P_IF4, HBIS_P_IF3, HBIS_P_NONE, HBIS_P_M68A,
        HBIS_P_NONE, HBIS_P_M68B, HBIS_P_NONE};
    hbis_top hbis_top_inst (.mclk, .rst_b, .host_bus_clock, .host_bus_select_straps,
        .misc_config_straps, .bus_status_strap, .host_addr_in, .host_data_i, .host_data_o,
        .host_data_oe_b, .chip_select_b, .low_byte_write_strobe, .high_byte_write_strobe,
        .low_byte_read_strobe, .high_byte_read_strobe, .stall_b, .mem_addr, .mem_wdata,
        .mem_wbe, .mem_write, .mem_req, .mem_grant, .mem_rdata, .personality, .big_endian,
        .panel_power_out, .panel_power_on);
    hbis_mem_model hbis_mem_model_inst (.mclk, .rst_b, .mem_req, .mem_write, .mem_addr,
        .mem_wdata, .mem_wbe, .dly, .mem_grant, .mem_rdata);
    // ==========
    // clocks and hang guard
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        host_bus_clock = 0;
        #137;
        forever #400 host_bus_clock = ~host_bus_clock;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            final_report;
        end
    end
    // ==========
    // compare and report
    task chk(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask
    task final_report;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset with straps, then check latched configuration
    task boot(logic [2:0] s, logic b, logic [1:0] m, hbis_pers_e xp);
        host_bus_select_straps = s;
        bus_status_strap = b;
        misc_config_straps = m;
        rst_b = 0;
        repeat (4) @(posedge mclk);
        #2 rst_b = 1;
        repeat (5) @(posedge mclk);
        #2 panel_power_on = 1;
        repeat (2) @(posedge mclk);
        #2 chk("pers", {12'h000, xp}, {12'h000, personality});
        chk("endian", {15'h0000, m[0]}, {15'h0000, big_endian});
        chk("pwr_on", {15'h0000, m[1]}, {15'h0000, panel_power_out});
        panel_power_on = 0;
        repeat (2) @(posedge mclk);
        #2 chk("pwr_off", {15'h0000, ~m[1]}, {15'h0000, panel_power_out});
    endtask
    // one host cycle; pins are {rd1, rd0, we1, we0}, active low
    task acc(logic [3:0] pins, logic [15:0] a, d, logic [1:0] xbe, logic [15:0] xd, xoe);
        int n;
        logic wr;
        wr = (pins[1:0] != 2'h3);
        {high_byte_read_strobe, low_byte_read_strobe} = pins[3:2];
        {high_byte_write_strobe, low_byte_write_strobe} = pins[1:0];
        host_addr_in = a;
        host_data_i = d;
        chip_select_b = 0;
        n = 0;
        do begin @(posedge mclk); #2; n++; end while (mem_req !== 1'h1 && n < 100);
        chk("stall_lo", 16'h0000, {15'h0000, stall_b});
        chk("write", {15'h0000, wr}, {15'h0000, mem_write});
        chk("addr", a, mem_addr);
        if (wr) begin
            chk("wbe", {14'h0000, xbe}, {14'h0000, mem_wbe});
            chk("wdata", xd, mem_wdata);
        end
        n = 0;
        do begin @(posedge mclk); #2; n++; end while (host_cycle_done_b !== 1'h0 && n < 100);
        chk("stall_len", 16'h0001, {15'h0000, (n > dly && n < 100)});
        if (!wr) begin
            chk("oe", xoe, host_data_oe_b);
            chk("rdata", xd | xoe, host_data_o | xoe);
        end
        chip_select_b = 1;
        {high_byte_read_strobe, low_byte_read_strobe} = 2'h3;
        {high_byte_write_strobe, low_byte_write_strobe} = 2'h3;
        host_data_i = ~d;
        repeat (24) @(posedge mclk);
        #2 chk("oe_off", 16'hFFFF, host_data_oe_b);
    endtask
    // ==========
    // main sequence
    initial begin
        rst_b = 0;
        chip_select_b = 1;
        {low_byte_write_strobe, high_byte_write_strobe} = 2'h3;
        {low_byte_read_strobe, high_byte_read_strobe} = 2'h3;
        host_addr_in = 0;
        host_data_i = 0;
        panel_power_on = 0;
        dly = 1;
        boot(3'h7, 0, 2'h2, HBIS_P_GEN1);
        acc(4'hC, 16'h0004, 16'hA55A, 2'h3, 16'hA55A, 0);
        acc(4'hE, 16'h0006, 16'h0011, 2'h1, 16'h0011, 0);
        acc(4'hD, 16'h0006, 16'h2200, 2'h2, 16'h2200, 0);
        dly = 9;
        acc(4'h3, 16'h0004, 0, 0, 16'hA55A, 16'h0000);
        dly = 1;
        acc(4'h7, 16'h0006, 0, 0, 16'h2200, 16'h00FF);
        acc(4'hB, 16'h0006, 0, 0, 16'h0011, 16'hFF00);
        $display("test generic one done");
        boot(3'h7, 0, 2'h1, HBIS_P_GEN1);
        acc(4'hE, 16'h0002, 16'h1234, 2'h2, 16'h3412, 0);
        acc(4'hB, 16'h0002, 0, 0, 16'h0034, 16'hFF00);
        $display("test byte order done");
        boot(3'h7, 1, 2'h0, HBIS_P_GEN2);
        acc(4'hC, 16'h0008, 16'hBEEF, 2'h3, 16'hBEEF, 0);
        $display("test generic two done");
        for (int i = 0; i < 7; i++) begin
            boot(i[2:0], 0, 2'h2, xp_tab[i]);
            if (xp_tab[i] == HBIS_P_M68A) acc(4'h5, 16'h000A, 16'h5AA5, 2'h3, 16'h5AA5, 0);
            if (xp_tab[i] == HBIS_P_NONE) begin
                chip_select_b = 0;
                low_byte_write_strobe = 0;
                repeat (30) @(posedge mclk);
                #2 chk("refuse", 16'h0000, {15'h0000, mem_req});
                chip_select_b = 1;
                low_byte_write_strobe = 1;
            end
        end
        $display("test strap table done");
        final_report;
    end
endmodule // hbis_tb

// ===== hdl/hbis_pkg.sv
// Functional notes
// RULE1: latch three bus-select straps and bus-status strap at reset release.
// RULE2: sixteen-bit host port with six selectable bus personalities.
// RULE3: pins take latched personality's function until next reset.
// RULE4: also latch endian strap and panel power polarity strap at reset.
// RULE5: endian choice applies independently of bus personality.
// RULE6: generic one: chip select plus per-byte read and write strobes.
// RULE7: host logic runs from dedicated host bus clock, not core clock; here it runs on mclk and samples host_bus_clock edges.
// RULE8: host wires data lanes per its width and byte order.
// RULE9: external logic decodes high address lines into chip select.
// RULE10: write strobes low per byte; device stores only strobed bytes.
// RULE11: read strobes low per byte; device drives requested byte lanes.
// RULE12: stall output held low until arbitration grants the access.
// RULE13: glue inverts stall output when host wait polarity differs.
// RULE14: board ties bus-status low for generic one; strap only.
// RULE15: acknowledge inverter enabled only during chip select.
// RULE16: generic two: high-byte enable, shared read and write strobes.
// RULE17: 68k one: address bit zero lower strobe, high write upper strobe.
// RULE18: 68k two: data on host bits 31:16, size pins, port-size acknowledge; here no port-size acknowledge is driven, only stall_b.
package hbis_pkg;
    typedef enum logic [2:0] {
        HBIS_SEL_IF4 = 3'h0,
        HBIS_SEL_IF3 = 3'h1,
        HBIS_SEL_RSV2 = 3'h2,
        HBIS_SEL_M68A = 3'h3,
        HBIS_SEL_RSV4 = 3'h4,
        HBIS_SEL_M68B = 3'h5,
        HBIS_SEL_RSV6 = 3'h6,
        HBIS_SEL_GEN = 3'h7
    } hbis_sel_e;
    typedef enum logic [3:0] {
        HBIS_P_NONE = 4'h0,
        HBIS_P_IF4 = 4'h1,
        HBIS_P_IF3 = 4'h2,
        HBIS_P_M68A = 4'h3,
        HBIS_P_M68B = 4'h4,
        HBIS_P_GEN1 = 4'h5,
        HBIS_P_GEN2 = 4'h6
    } hbis_pers_e;
    typedef enum logic [1:0] {
        HBIS_ST_IDLE = 2'h0,
        HBIS_ST_REQ = 2'h1,
        HBIS_ST_DONE = 2'h2
    } hbis_state_e;
    localparam int HBIS_DATA_W = 16;
    localparam logic [15:0] HBIS_DATA_RST = 16'h0000;
    localparam logic [2:0] HBIS_STRAP_RST = 3'h0;
endpackage

// ===== hdl/hbis_top.sv
`timescale 1ns/10ps
// host bus port with personality straps; mclk is the core clock
module hbis_top
    import hbis_pkg::*;
#(
    parameter int AW = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic host_bus_clock,
    input wire logic [2:0] host_bus_select_straps,
    input wire logic [1:0] misc_config_straps,
    input wire logic bus_status_strap,
    input wire logic [AW-1:0] host_addr_in,
    input wire logic [15:0] host_data_i,
    output logic [15:0] host_data_o,
    output logic [15:0] host_data_oe_b,
    input wire logic chip_select_b,
    input wire logic low_byte_write_strobe,
    input wire logic high_byte_write_strobe,
    input wire logic low_byte_read_strobe,
    input wire logic high_byte_read_strobe,
    output logic stall_b,
    output logic [AW-1:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic [1:0] mem_wbe,
    output logic mem_write,
    output logic mem_req,
    input wire logic mem_grant,
    input wire logic [15:0] mem_rdata,
    output logic [3:0] personality,
    output logic big_endian,
    output logic panel_power_out,
    input wire logic panel_power_on
);
    // ==========================================
    // input synchronisers
    localparam int SW = AW + 28;
    logic [SW-1:0] s1_q, s2_q;
    logic bclk_prev_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            bclk_prev_q <= 1'b0;
        end else begin
            s1_q <= {host_bus_clock, bus_status_strap, misc_config_straps,
                     host_bus_select_straps, chip_select_b, low_byte_write_strobe,
                     high_byte_write_strobe, low_byte_read_strobe,
                     high_byte_read_strobe, host_addr_in, host_data_i};
            s2_q <= s1_q;
            bclk_prev_q <= s2_q[SW-1];
        end
    end
    wire bclk_s = s2_q[SW-1];
    wire bclk_rise = bclk_s & ~bclk_prev_q; // host clock edge found by sampling [RULE7]
    wire bs_s = s2_q[SW-2];
    wire [1:0] misc_s = s2_q[SW-3 -: 2];
    wire [2:0] sel_s = s2_q[SW-5 -: 3];
    wire cs_s = s2_q[AW+20];
    wire we0_s = s2_q[AW+19];
    wire we1_s = s2_q[AW+18];
    wire rd0_s = s2_q[AW+17];
    wire rd1_s = s2_q[AW+16];
    wire [AW-1:0] a_s = s2_q[AW+15 -: AW];
    wire [15:0] d_s = s2_q[15:0];

    // ==========================================
    // strap latch on the third clock edge after reset release
    logic latched_q;
    logic [3:0] pers_q;
    logic endian_q, pwr_pol_q;
    logic [1:0] arm_q;
    function automatic logic [3:0] decode_pers(input logic [2:0] s, input logic b);
        case (s)
            HBIS_SEL_IF4: decode_pers = HBIS_P_IF4;
            HBIS_SEL_IF3: decode_pers = HBIS_P_IF3;
            HBIS_SEL_M68A: decode_pers = HBIS_P_M68A;
            HBIS_SEL_M68B: decode_pers = HBIS_P_M68B;
            HBIS_SEL_GEN: decode_pers = b ? HBIS_P_GEN2 : HBIS_P_GEN1;
            default: decode_pers = HBIS_P_NONE;
        endcase
    endfunction
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            arm_q <= 2'h0;
            latched_q <= 1'b0;
            pers_q <= HBIS_P_NONE;
            endian_q <= 1'b0;
            pwr_pol_q <= 1'b0;
        end else begin
            arm_q <= {arm_q[0], 1'b1};
            if (arm_q[1] && !latched_q) begin // sync chain holds pins seen after release
                latched_q <= 1'b1;
                pers_q <= decode_pers(sel_s, bs_s); // [RULE1] [RULE2] [RULE3]
                endian_q <= misc_s[0]; // [RULE4] [RULE5]
                pwr_pol_q <= misc_s[1]; // [RULE4]
            end
        end
    end

    // ==========================================
    // per-personality strobe decode
    logic rd_lo, rd_hi, wr_lo, wr_hi, cyc_act;
    always_comb begin
        rd_lo = 1'b0;
        rd_hi = 1'b0;
        wr_lo = 1'b0;
        wr_hi = 1'b0;
        case (pers_q)
            HBIS_P_GEN1: begin // [RULE6] [RULE10] [RULE11]
                wr_lo = !we0_s;
                wr_hi = !we1_s;
                rd_lo = !rd0_s;
                rd_hi = !rd1_s;
            end
            HBIS_P_GEN2: begin // [RULE16] high-byte enable low selects upper lane
                wr_lo = !we0_s & !a_s[0];
                wr_hi = !we0_s & !we1_s;
                rd_lo = !rd0_s & !a_s[0];
                rd_hi = !rd0_s & !we1_s;
            end
            HBIS_P_M68A: begin // [RULE17] bs acts as address strobe
                wr_lo = !bs_s & !a_s[0] & !rd1_s;
                wr_hi = !bs_s & !we1_s & !rd1_s;
                rd_lo = !bs_s & !a_s[0] & rd1_s;
                rd_hi = !bs_s & !we1_s & rd1_s;
            end
            HBIS_P_M68B: begin // [RULE18] size pins on read/write-low pins
                wr_hi = !bs_s & !we1_s & !rd1_s;
                wr_lo = wr_hi & !(rd0_s == 1'b0 && we0_s == 1'b1 && !a_s[0]);
                wr_hi = wr_hi & !(rd0_s == 1'b0 && we0_s == 1'b1 && a_s[0]);
                rd_hi = !bs_s & !we1_s & rd1_s;
                rd_lo = rd_hi;
            end
            HBIS_P_IF3, HBIS_P_IF4: begin
                wr_lo = !bs_s & !we0_s;
                wr_hi = !bs_s & !we1_s;
                rd_lo = !bs_s & !rd0_s;
                rd_hi = !bs_s & !rd0_s;
            end
            default: ;
        endcase
        cyc_act = latched_q & !cs_s & (rd_lo | rd_hi | wr_lo | wr_hi);
    end
    // byte swap when big endian is strapped
    wire [15:0] d_in = endian_q ? {d_s[7:0], d_s[15:8]} : d_s; // [RULE5]
    wire [15:0] d_out = endian_q ? {mem_rdata[7:0], mem_rdata[15:8]} : mem_rdata;
    wire [1:0] be_in = endian_q ? {wr_lo, wr_hi} : {wr_hi, wr_lo};
    wire [1:0] rbe = {rd_hi, rd_lo};

    // ==========================================
    // access sequencer
    hbis_state_e st_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= HBIS_ST_IDLE;
            stall_b <= 1'b1;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= HBIS_DATA_RST;
            mem_wbe <= 2'h0;
            host_data_o <= HBIS_DATA_RST;
            host_data_oe_b <= 16'hFFFF;
        end else begin
            case (st_q)
                HBIS_ST_IDLE: begin
                    stall_b <= !cyc_act; // hold the host off from first sight of a cycle [RULE12]
                    if (cyc_act && bclk_rise) begin
                        st_q <= HBIS_ST_REQ;
                        stall_b <= 1'b0; // [RULE12]
                        mem_req <= 1'b1;
                        mem_write <= |be_in;
                        mem_addr <= a_s;
                        mem_wdata <= d_in;
                        mem_wbe <= be_in; // [RULE10]
                    end
                end
                HBIS_ST_REQ: begin
                    if (mem_grant) begin // stall released only on grant [RULE12]
                        st_q <= HBIS_ST_DONE;
                        mem_req <= 1'b0;
                        stall_b <= 1'b1;
                        if (!mem_write) begin
                            host_data_o <= d_out;
                            host_data_oe_b <= ~{{8{rbe[1]}}, {8{rbe[0]}}}; // [RULE11]
                        end
                    end
                end
                HBIS_ST_DONE: begin
                    if (!cyc_act) begin
                        st_q <= HBIS_ST_IDLE;
                        host_data_oe_b <= 16'hFFFF;
                    end
                end
                default: st_q <= HBIS_ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // status outputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            personality <= HBIS_P_NONE;
            big_endian <= 1'b0;
            panel_power_out <= 1'b0;
        end else begin
            personality <= pers_q;
            big_endian <= endian_q;
            panel_power_out <= latched_q & (panel_power_on ~^ pwr_pol_q); // [RULE4]
        end
    end

    // ==========================================
    // checks
    property p_stall_until_grant;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == HBIS_ST_REQ && !mem_grant) |=> !stall_b;
    endproperty
    a_stall_until_grant: assert property (p_stall_until_grant) else $error("stall lost"); // [RULE12]
    property p_pers_stable;
        @(posedge mclk) disable iff (!rst_b)
        latched_q |=> $stable(pers_q) && $stable(endian_q);
    endproperty
    a_pers_stable: assert property (p_pers_stable) else $error("personality changed"); // [RULE3]
    property p_latch_time;
        @(posedge mclk) disable iff (!rst_b)
        $rose(arm_q[1]) |=> latched_q;
    endproperty
    a_latch_time: assert property (p_latch_time) else $error("straps not latched"); // [RULE1]
    property p_wbe_match;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == HBIS_ST_REQ && mem_write) |-> mem_wbe != 2'h0;
    endproperty
    a_wbe_match: assert property (p_wbe_match) else $error("write with no bytes"); // [RULE10]
    property p_drive_read;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == HBIS_ST_REQ && mem_grant && !mem_write) |=> host_data_oe_b != 16'hFFFF;
    endproperty
    a_drive_read: assert property (p_drive_read) else $error("read not driven"); // [RULE11]
    property p_start_stall;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == HBIS_ST_IDLE && cyc_act && bclk_rise) |=> !stall_b && mem_req;
    endproperty
    a_start_stall: assert property (p_start_stall) else $error("no stall on start"); // [RULE7]
    property p_gen1_map;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == HBIS_ST_IDLE && cyc_act && bclk_rise && pers_q == HBIS_P_GEN1 && !endian_q)
            |=> mem_wbe == ~$past({we1_s, we0_s});
    endproperty
    a_gen1_map: assert property (p_gen1_map) else $error("generic map wrong"); // [RULE6]
    property p_endian;
        @(posedge mclk) disable iff (!rst_b)
        (st_q == HBIS_ST_IDLE && cyc_act && bclk_rise && endian_q) |=> mem_wdata[7:0] == $past(d_s[15:8]);
    endproperty
    a_endian: assert property (p_endian) else $error("byte order wrong"); // [RULE5]
endmodule // hbis_top
